// >>> line_pulse_pkg.sv
// Shared constants and carriers for the line pulse signal controller
package line_pulse_pkg;

  localparam int unsigned CLK_HZ        = 20_000_000;
  localparam int unsigned CYC_PER_US    = CLK_HZ / 1_000_000;
  // One duration step of a pulse, and the whole fixed gap between pulses
  localparam int unsigned PULSE_UNIT_US = 10_000;
  localparam int unsigned GAP_UNIT_US   = 10_000;
  localparam int unsigned PULSE_UNIT_CYC = PULSE_UNIT_US * CYC_PER_US;
  localparam int unsigned GAP_UNIT_CYC   = GAP_UNIT_US * CYC_PER_US;

  localparam logic [1:0] SUPP_NONE     = 2'h0;
  localparam logic [1:0] SUPP_EXCH     = 2'h1;
  localparam logic [1:0] SUPP_TERM     = 2'h2;
  localparam logic [1:0] SUPP_DEFAULT  = 2'h3;
  localparam logic [2:0] DUR_DEFAULT   = 3'h0;
  localparam logic [4:0] COUNT_DEFAULT = 5'h01;
  localparam logic [4:0] COUNT_ZERO    = 5'h00;
  localparam logic [4:0] COUNT_MAX_DIAL = 5'h0F;
  localparam logic [6:0] RING_DEFAULT  = 7'h00;
  localparam logic [4:0] PK_NORMAL_POL = 5'h00;
  localparam logic [4:0] PK_REVERSE_POL = 5'h01;
  localparam logic [7:0] RING_AC_BASE  = 8'h40;
  localparam logic [7:0] RING_DC_BASE  = 8'h10;
  localparam logic [7:0] RING_FREQ_BASE = 8'h19;

  typedef struct packed {
    logic [4:0] pulse_type;
    logic       supp_present;
    logic [1:0] supp;
    logic       dur_present;
    logic [2:0] dur_type;
    logic       ack_present;
    logic       ack_each;
    logic       count_present;
    logic [4:0] count;
    logic       dialled;
  } pulse_cmd_s;

  typedef struct packed {
    logic [7:0] ac_level;
    logic [7:0] dc_level;
    logic [7:0] freq;
    logic [3:0] cad_on;
    logic [3:0] cad_off;
  } ring_params_s;

endpackage

// >>> line_pulse_signal_controller.sv
// Per-line pulsed signal, ringing and response controller
`timescale 1ns/1ps
module line_pulse_signal_controller #(
  parameter int unsigned PULSE_UNIT_CYC = line_pulse_pkg::PULSE_UNIT_CYC,
  parameter int unsigned GAP_UNIT_CYC   = line_pulse_pkg::GAP_UNIT_CYC,
  parameter bit          SUPP_IMMEDIATE = 1'b0
) (
  input  wire logic                         sys_clk,
  input  wire logic                         rst_b,
  input  wire logic                         cmd_valid,
  input  wire line_pulse_pkg::pulse_cmd_s   cmd,
  output logic                              cmd_ready,
  output logic                              cmd_error,
  input  wire logic                         ring_start,
  input  wire logic [6:0]                   ring_type,
  input  wire logic                         ring_stop,
  output logic                              ring_active,
  output line_pulse_pkg::ring_params_s      ring_params,
  input  wire logic                         exch_msg,
  input  wire logic                         block_msg,
  input  wire logic                         term_line,
  input  wire logic                         steady_reversed,
  output logic                              pulse_on,
  output logic [4:0]                        pulse_kind,
  output logic                              line_reversed,
  output logic                              ack_valid,
  output logic                              seq_complete,
  input  wire logic                         rx_pulse_valid,
  input  wire logic [2:0]                   rx_pulse_dur,
  output logic                              report_valid,
  output logic [2:0]                        report_dur,
  input  wire logic                         aseq_done,
  input  wire logic [3:0]                   aseq_result,
  output logic                              seq_resp_valid,
  output logic [3:0]                        seq_resp_code
);

  if (PULSE_UNIT_CYC < 1 || GAP_UNIT_CYC < 1 ||
      PULSE_UNIT_CYC > 32'h1000_0000 || GAP_UNIT_CYC > 32'h1000_0000)
  begin : g_bad_timing
    $error("Pulse or gap unit out of range");
  end

  typedef enum logic [1:0] {ST_IDLE, ST_ON, ST_GAP} pulse_st_e;

  pulse_st_e   state;
  logic [31:0] timer;
  logic [4:0]  remaining;
  logic [1:0]  cur_supp;
  logic [2:0]  cur_dur;
  logic        cur_ack;
  logic        cur_each;
  logic        inhibit;
  logic        term_meta;
  logic        term_sync;
  logic        term_prev;

  ////////////////////////////////////////////////////////////////////////
  // Ringing type table
  function automatic line_pulse_pkg::ring_params_s ring_lookup(
    input logic [6:0] t
  );
    line_pulse_pkg::ring_params_s p;
    p.ac_level = line_pulse_pkg::RING_AC_BASE + {1'b0, t};
    p.dc_level = line_pulse_pkg::RING_DC_BASE + {4'h0, t[6:3]};
    p.freq     = line_pulse_pkg::RING_FREQ_BASE + {5'h00, t[2:0]};
    p.cad_on   = t[3:0] + 4'h1;
    p.cad_off  = ~t[3:0];
    return p;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Command decode
  wire        busy        = (state != ST_IDLE);
  wire        accept      = cmd_valid & cmd_ready;
  wire [4:0]  count_eff   = cmd.count_present ? cmd.count
                                              : line_pulse_pkg::COUNT_DEFAULT;
  wire        count_zero  = (count_eff == line_pulse_pkg::COUNT_ZERO);
  wire        count_over  = cmd.dialled &
                            (count_eff > line_pulse_pkg::COUNT_MAX_DIAL);
  wire        cmd_bad     = count_zero | count_over;
  wire [1:0]  supp_eff    = cmd.supp_present ? cmd.supp
                                             : line_pulse_pkg::SUPP_DEFAULT;
  wire [2:0]  dur_eff     = cmd.dur_present ? cmd.dur_type
                                            : line_pulse_pkg::DUR_DEFAULT;
  wire        ack_eff     = cmd.ack_present;
  wire        term_evt    = term_sync ^ term_prev;
  wire        supp_hit    = busy & (block_msg |
                            (cur_supp[0] & exch_msg) |
                            (cur_supp[1] & term_evt));
  wire [31:0] on_len      = PULSE_UNIT_CYC * ({29'h0, cur_dur} + 32'h1);
  wire        on_end      = (state == ST_ON) & (timer == on_len - 32'h1);
  wire        gap_end     = (state == ST_GAP) &
                            (timer == GAP_UNIT_CYC - 32'h1);
  wire        last_end    = on_end & ((remaining == 5'h01) | inhibit |
                                      supp_hit);
  wire        abort_now   = supp_hit & (SUPP_IMMEDIATE | (state == ST_GAP));
  wire        seq_end     = last_end | (abort_now & busy);

  ////////////////////////////////////////////////////////////////////////
  // Terminal condition synchroniser
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      term_meta <= 1'b0;
      term_sync <= 1'b0;
      term_prev <= 1'b0;
    end else begin
      term_meta <= term_line;
      term_sync <= term_meta;
      term_prev <= term_sync;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Pulse sequencer
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      state        <= ST_IDLE;
      timer        <= 32'h0000_0000;
      remaining    <= 5'h00;
      cur_supp     <= line_pulse_pkg::SUPP_DEFAULT;
      cur_dur      <= line_pulse_pkg::DUR_DEFAULT;
      cur_ack      <= 1'b0;
      cur_each     <= 1'b0;
      inhibit      <= 1'b0;
      pulse_kind   <= line_pulse_pkg::PK_NORMAL_POL;
      cmd_ready    <= 1'b1;
      cmd_error    <= 1'b0;
      ack_valid    <= 1'b0;
      seq_complete <= 1'b0;
    end else begin
      cmd_error    <= 1'b0;
      ack_valid    <= 1'b0;
      seq_complete <= 1'b0;
      unique case (state)
        ST_IDLE: begin
          if (accept && cmd_bad) begin
            cmd_error <= 1'b1;
          end else if (accept) begin
            state      <= ST_ON;
            cmd_ready  <= 1'b0;
            timer      <= 32'h0000_0000;
            remaining  <= count_eff;
            cur_supp   <= supp_eff;
            cur_dur    <= dur_eff;
            cur_ack    <= ack_eff;
            cur_each   <= cmd.ack_each;
            pulse_kind <= cmd.pulse_type;
            inhibit    <= 1'b0;
          end
        end
        ST_ON, ST_GAP: begin
          if (seq_end) begin
            state        <= ST_IDLE;
            cmd_ready    <= 1'b1;
            seq_complete <= 1'b1;
            remaining    <= on_end ? remaining - 5'h01 : remaining;
            ack_valid    <= cur_ack & (~cur_each | on_end);
          end else if (on_end) begin
            state     <= ST_GAP;
            timer     <= 32'h0000_0000;
            remaining <= remaining - 5'h01;
            ack_valid <= cur_ack & cur_each;
          end else if (gap_end) begin
            state <= ST_ON;
            timer <= 32'h0000_0000;
          end else begin
            timer <= timer + 32'h0000_0001;
            if (supp_hit) begin
              inhibit <= 1'b1;
            end
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Line drive, ringing and outward reports
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      pulse_on      <= 1'b0;
      line_reversed <= 1'b0;
    end else begin
      pulse_on <= (state == ST_ON);
      if (pulse_on && pulse_kind == line_pulse_pkg::PK_REVERSE_POL) begin
        line_reversed <= ~steady_reversed;
      end else if (pulse_on && pulse_kind == line_pulse_pkg::PK_NORMAL_POL)
      begin
        line_reversed <= 1'b0;
      end else begin
        line_reversed <= steady_reversed;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      ring_active <= 1'b0;
      ring_params <= '0;
    end else if (ring_start) begin
      ring_active <= 1'b1;
      ring_params <= ring_lookup(ring_type);
    end else if (ring_stop) begin
      ring_active <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      report_valid   <= 1'b0;
      report_dur     <= line_pulse_pkg::DUR_DEFAULT;
      seq_resp_valid <= 1'b0;
      seq_resp_code  <= 4'h0;
    end else begin
      report_valid <= rx_pulse_valid &
                      (rx_pulse_dur != line_pulse_pkg::DUR_DEFAULT);
      if (rx_pulse_valid) begin
        report_dur <= rx_pulse_dur;
      end
      seq_resp_valid <= aseq_done;
      if (aseq_done) begin
        seq_resp_code <= aseq_result;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  sequence s_pulse_start;
    pulse_kind == $past(cmd.pulse_type) && !cmd_ready ##1 pulse_on;
  endsequence

  a_zero_count_drop: assert property (
    accept && count_zero |=> cmd_error && !busy ##1 !pulse_on)
    else $error("Zero count command not dropped");
  a_dial_count_limit: assert property (
    accept && count_over |=> cmd_error && !busy)
    else $error("Dialled count above fifteen accepted");
  a_pulse_start_kind: assert property (
    accept && !cmd_bad |=> s_pulse_start)
    else $error("Pulse not started with requested kind");
  a_default_one_pulse: assert property (
    accept && !cmd_bad && !cmd.count_present |=> remaining == 5'h01)
    else $error("Missing count did not give one pulse");
  a_default_supp_val: assert property (
    accept && !cmd_bad && !cmd.supp_present |=> cur_supp == 2'h3)
    else $error("Missing suppression did not default");
  a_default_dur_zero: assert property (
    accept && !cmd_bad && !cmd.dur_present |=> cur_dur == 3'h0)
    else $error("Missing duration did not default");
  a_no_supp_hold: assert property (
    busy && cur_supp == line_pulse_pkg::SUPP_NONE && !block_msg &&
    !last_end |=> busy)
    else $error("Unsuppressible pulses stopped");
  a_exch_only_hold: assert property (
    busy && cur_supp == line_pulse_pkg::SUPP_EXCH && !exch_msg &&
    !block_msg && !last_end |=> busy)
    else $error("Terminal change stopped exchange-only pulses");
  a_term_only_hold: assert property (
    busy && cur_supp == line_pulse_pkg::SUPP_TERM && !term_evt &&
    !block_msg && !last_end |=> busy)
    else $error("Exchange message stopped terminal-only pulses");
  a_both_stop_gap: assert property (
    state == ST_GAP && cur_supp == line_pulse_pkg::SUPP_DEFAULT &&
    (exch_msg || term_evt) |=> !busy && seq_complete)
    else $error("Suppression did not end the sequence");
  a_line_revert: assert property (
    !pulse_on |=> line_reversed == $past(steady_reversed))
    else $error("Line not back to prior condition");
  a_ring_default: assert property (
    ring_start && ring_type == line_pulse_pkg::RING_DEFAULT |=>
    ring_active && ring_params == ring_lookup(7'h00))
    else $error("Default ringing not applied");
  a_resp_cause: assert property (
    seq_resp_valid |-> $past(aseq_done) &&
                       seq_resp_code == $past(aseq_result))
    else $error("Sequence response without sequence end");

endmodule

// >>> exchange_model.sv
// Exchange side model: issues pulse commands and line messages
`timescale 1ns/1ps
module exchange_model (
  input  wire logic                  sys_clk,
  input  wire logic                  cmd_ready,
  output logic                       cmd_valid,
  output line_pulse_pkg::pulse_cmd_s cmd,
  output logic                       exch_msg,
  output logic                       block_msg
);
  initial begin
    cmd_valid = 1'b0;
    cmd = '0;
    exch_msg = 1'b0;
    block_msg = 1'b0;
  end
  // Offer at falling edge, hold until taken at a rising edge
  task automatic send(input  line_pulse_pkg::pulse_cmd_s c,
                      output bit                         late);
    int n;
    n = 0;
    @(negedge sys_clk);
    cmd_valid = 1'b1;
    cmd = c;
    @(posedge sys_clk);
    while (!cmd_ready && n < 1000) begin
      @(posedge sys_clk);
      n++;
    end
    late = (n >= 1000);
    @(negedge sys_clk);
    cmd_valid = 1'b0;
    cmd = ~c;
  endtask
  // One-cycle message: 0 new exchange message, 1 blocking message
  task automatic message(input int kind);
    @(negedge sys_clk);
    exch_msg = (kind == 0);
    block_msg = (kind == 1);
    @(negedge sys_clk);
    exch_msg = 1'b0;
    block_msg = 1'b0;
  endtask
endmodule

// >>> tb.sv
// Self-checking bench for the line pulse signal controller
`timescale 1ns/1ps
module tb;
  localparam int PU = 4;
  localparam int GU = 4;
  logic       sys_clk, rst_b, cmd_valid, cmd_ready, cmd_error, prev_on;
  logic       ring_start, ring_stop, ring_active, exch_msg, block_msg;
  logic       term_line, steady_reversed, pulse_on, line_reversed;
  logic       ack_valid, seq_complete, rx_pulse_valid, report_valid;
  logic       aseq_done, seq_resp_valid;
  logic [6:0] ring_type;
  logic [4:0] pulse_kind;
  logic [2:0] rx_pulse_dur, report_dur, rdur;
  logic [3:0] aseq_result, seq_resp_code, rcode;
  line_pulse_pkg::pulse_cmd_s   cmd;
  line_pulse_pkg::ring_params_s ring_params, p5;
  int n_pulse, n_on, n_ack, n_done, n_err, n_rep, n_resp;
  int n_errors = 0;
  int n_compared = 0;

  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  line_pulse_signal_controller #(.PULSE_UNIT_CYC(PU), .GAP_UNIT_CYC(GU)) DUT (
    .sys_clk(sys_clk), .rst_b(rst_b), .cmd_valid(cmd_valid), .cmd(cmd),
    .cmd_ready(cmd_ready), .cmd_error(cmd_error), .ring_start(ring_start),
    .ring_type(ring_type), .ring_stop(ring_stop), .ring_active(ring_active),
    .ring_params(ring_params), .exch_msg(exch_msg), .block_msg(block_msg),
    .term_line(term_line), .steady_reversed(steady_reversed),
    .pulse_on(pulse_on), .pulse_kind(pulse_kind),
    .line_reversed(line_reversed), .ack_valid(ack_valid),
    .seq_complete(seq_complete), .rx_pulse_valid(rx_pulse_valid),
    .rx_pulse_dur(rx_pulse_dur), .report_valid(report_valid),
    .report_dur(report_dur), .aseq_done(aseq_done),
    .aseq_result(aseq_result), .seq_resp_valid(seq_resp_valid),
    .seq_resp_code(seq_resp_code));

  exchange_model exch (.sys_clk(sys_clk), .cmd_ready(cmd_ready),
    .cmd_valid(cmd_valid), .cmd(cmd), .exch_msg(exch_msg),
    .block_msg(block_msg));

  ////////////////////////////////////////////////////////////////////////////
  always @(posedge sys_clk) begin
    prev_on <= pulse_on;
    if (pulse_on && !prev_on) n_pulse++;
    if (pulse_on) n_on++;
    if (ack_valid) n_ack++;
    if (seq_complete) n_done++;
    if (cmd_error) n_err++;
    if (report_valid) n_rep++;
    if (report_valid) rdur = report_dur;
    if (seq_resp_valid) n_resp++;
    if (seq_resp_valid) rcode = seq_resp_code;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict();
    $display("compared %0d, errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  function automatic line_pulse_pkg::pulse_cmd_s mk(input logic [4:0] pt,
    input logic sp, input logic [1:0] s, input logic dp, input logic [2:0] d,
    input logic ap, input logic ae, input logic cp, input logic [4:0] c,
    input logic dl);
    return '{pt, sp, s, dp, d, ap, ae, cp, c, dl};
  endfunction

  task automatic strobe(ref logic s);
    @(negedge sys_clk);
    s = 1'b1;
    @(negedge sys_clk);
    s = 1'b0;
    repeat (2) @(negedge sys_clk);
  endtask

  task automatic wait_sig(input int idle);
    int n;
    n = 0;
    while (!(idle ? cmd_ready && n_done > 0 : pulse_on) && n < 2000) begin
      @(posedge sys_clk);
      n++;
    end
    if (n >= 2000) n_errors++;
  endtask

  // Offer through the model; a command never taken counts as an error
  task automatic offer(input line_pulse_pkg::pulse_cmd_s c);
    bit late;
    exch.send(c, late);
    if (late) n_errors++;
  endtask

  // Offer one command, let it run out, then compare the tallies
  task automatic run(input line_pulse_pkg::pulse_cmd_s c, input int p, on,
    input int ak, input int er);
    @(negedge sys_clk);
    {n_pulse, n_on, n_ack, n_done, n_err} = '0;
    offer(c);
    if (er == 0) wait_sig(1);
    repeat (3) @(posedge sys_clk);
    check(n_pulse, p);
    check(n_on, on);
    check(n_ack, ak);
    check(n_err, er);
    check(n_done, er == 0);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Last suppression case: default indicator, message lands in the gap
  logic [1:0] sv[11] = '{0, 0, 0, 1, 1, 2, 2, 3, 3, 0, 3};
  int         se[11] = '{0, 2, 1, 0, 2, 0, 2, 0, 2, 0, 0};
  int         sx[11] = '{3, 3, 1, 1, 3, 3, 1, 1, 1, 1, 1};
  logic [4:0] cn[4]  = '{0, 16, 15, 31};
  logic       dl[4]  = '{0, 1, 1, 0};
  int         xp[4]  = '{0, 0, 15, 31};

  initial begin
    {ring_start, ring_stop, term_line, steady_reversed} = '0;
    {rx_pulse_valid, aseq_done, rst_b} = '0;
    {ring_type, rx_pulse_dur, aseq_result} = '0;
    repeat (2) @(posedge sys_clk);
    @(negedge sys_clk);
    rst_b = 1'b1;
    run(mk('0, '0, '0, '0, 3'h3, '0, '0, '0, 5'h07, '0), 1, PU, 0, 0);
    for (int a = 0; a < 2; a++) begin
      run(mk(5'h03, '0, '0, '1, 3'h1, '1, a[0], '1, 5'h03, '0), 3, 6 * PU,
        a ? 3 : 1, 0);
    end
    for (int i = 0; i < 4; i++) begin
      run(mk(5'h02, '0, '0, '0, '0, '0, '0, '1, cn[i], dl[i]), xp[i],
        xp[i] * PU, 0, 1 - (xp[i] > 0));
    end
    check(n_resp, 0);
    for (int i = 0; i < 11; i++) begin
      @(negedge sys_clk);
      {n_pulse, n_on, n_ack, n_done} = '0;
      offer(mk(5'h04, i < 9, sv[i], '1, 3'h3, '1, '0, '1, 5'h03, '0));
      wait_sig(0);
      repeat (i == 10 ? 16 : 2) @(negedge sys_clk);
      if (se[i] == 2) term_line = ~term_line;
      else exch.message(se[i]);
      wait_sig(1);
      check(n_pulse, sx[i]);
      check(n_on, sx[i] * PU * 4);
      check(n_ack, 1);
    end
    @(negedge sys_clk);
    term_line = ~term_line;
    repeat (6) @(posedge sys_clk);
    run(mk(5'h04, '0, '0, '0, '0, '0, '0, '1, 5'h03, '0), 3, 3 * PU, 0, 0);
    @(negedge sys_clk);
    steady_reversed = 1'b1;
    for (int k = 0; k < 3; k++) begin
      @(negedge sys_clk);
      n_done = 0;
      offer(mk(5'(k * k * 2 - k), '0, '0, '1, 3'h3, '0, '0, '0, '0, '0));
      wait_sig(0);
      repeat (4) @(posedge sys_clk);
      check(pulse_kind, k * k * 2 - k);
      check(line_reversed, k == 2);
      wait_sig(1);
      repeat (2) @(posedge sys_clk);
      check(line_reversed, 1);
    end
    @(negedge sys_clk);
    ring_type = 7'h05;
    strobe(ring_start);
    check(ring_active, 1);
    p5 = ring_params;
    strobe(ring_stop);
    check(ring_active, 0);
    ring_type = 7'h00;
    strobe(ring_start);
    check(ring_active, 1);
    ring_type = 7'h05;
    strobe(ring_start);
    check(ring_params, p5);
    rx_pulse_dur = 3'h0;
    strobe(rx_pulse_valid);
    check(n_rep, 0);
    rx_pulse_dur = 3'h3;
    strobe(rx_pulse_valid);
    check(n_rep, 1);
    check(rdur, 3'h3);
    aseq_result = 4'hA;
    strobe(aseq_done);
    check(n_resp, 1);
    check(rcode, 4'hA);
    give_verdict();
  end

  initial begin
    #1_000_000;
    n_errors++;
    give_verdict();
  end
endmodule
